//--- rtl/lscl_pkg.sv
// Constants, carriers and level coding for the LCD segment column loader
package lscl_pkg;

    // Geometry of the column register
    localparam int COLS      = 80;
    localparam int NIB_W     = 4;
    localparam int STEPS     = COLS / NIB_W;
    localparam int CNT_W     = 5;
    localparam int FIFO_DEPTH = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LATCH0 = 8'h08;
    localparam logic [7:0] OFS_LATCH1 = 8'h0C;
    localparam logic [7:0] OFS_LATCH2 = 8'h10;

    // Control fields and reset value
    localparam int          CTRL_HOLD_BIT = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Status field positions
    localparam int STAT_ACCEPT_BIT = 0;
    localparam int STAT_ENOUT_BIT  = 1;
    localparam int STAT_ENIN_BIT   = 2;
    localparam int STAT_FIFO_LSB   = 4;
    localparam int STAT_CNT_LSB    = 8;

    // Count value that marks a full line
    localparam logic [CNT_W-1:0] CNT_LAST  = 5'h13;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

    // Bias level selected for each segment output
    typedef enum logic [1:0] {
        LVL_UNSEL  = 2'h0,
        LVL_THIRD  = 2'h1,
        LVL_FOURTH = 2'h2,
        LVL_NEG    = 2'h3
    } lscl_level_type;

    // Pins coming from the controller and the neighbours
    typedef struct packed {
        logic             shift_strobe;
        logic             row_load;
        logic             polarity;
        logic             blank_n;
        logic             dir;
        logic             a_in;
        logic             b_in;
        logic [NIB_W-1:0] nib;
    } lscl_pins_type;

    localparam lscl_pins_type PINS_RESET = '{default: 1'b0};

    // One buffered nibble with the direction it was taken under
    typedef struct packed {
        logic             dir;
        logic [NIB_W-1:0] nib;
    } lscl_entry_type;

    // Four-way selection from polarity, latched bit and blanking
    function automatic lscl_level_type lscl_level_sel(input logic pol, input logic bit_v, input logic blank_n);
        if (!blank_n)
            return LVL_UNSEL;
        unique case ({pol, bit_v})
            2'b00:   return LVL_THIRD;
            2'b01:   return LVL_UNSEL;
            2'b10:   return LVL_FOURTH;
            default: return LVL_NEG;
        endcase
    endfunction

endpackage

//--- rtl/lscl_column_loader.sv
// Column loader: synchronised intake, two-entry buffer, shift, latch, bias select, APB view
// Contract
// RULE1 - Each accepted shift strobe falling edge shifts one nibble into the 80-bit register.
// RULE2 - Shift strobe edges are ignored while the accept flag is inactive.
// RULE3 - Row load strobe copies the whole shift register into the output latch.
// RULE4 - Row load strobe high level initialises the accept flag.
// RULE5 - Blanking low forces every segment to the unselected level.
// RULE6 - Polarity and bit select unselected, fourth or most negative level.
// RULE7 - Polarity low and bit low select the third bias level.
// RULE8 - Controller supplies the frame inversion waveform on the polarity input.
// RULE9 - Direction low: port B enable input, A output; high swaps them.
// RULE10 - Direction low fills upward from columns 1-4; high fills downward from 80.
// RULE11 - Enable input high stops intake, low starts it.
// RULE12 - Enable output goes high when the load strobe initialises the accept flag.
// RULE13 - Enable output goes low once all 80 bits are converted.
// RULE14 - Completion is twenty accepted strobes since the last load strobe.
// RULE15 - After completion the accept flag holds until the next load strobe.
// RULE16 - In a cascade, enable output of one driver feeds the next input.
// RULE17 - Intake stays idle while the enable input is at the disable level.
// RULE18 - Controller presents one nibble per shift strobe on the nibble inputs.
module lscl_column_loader
    import lscl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Controller pins
    input  wire logic                  data_shift_strobe,
    input  wire logic                  row_load_strobe,
    input  wire logic [NIB_W-1:0]      pixel_nibble,
    input  wire logic                  polarity,
    input  wire logic                  blanking_input_n,
    input  wire logic                  shift_direction_select,
    output logic                       intake_ready,
    // Chain enable pins, each split into in, out and active-low enable
    input  wire logic                  chain_port_a_in,
    output logic                       chain_port_a_out,
    output logic                       chain_port_a_oe_n,
    input  wire logic                  chain_port_b_in,
    output logic                       chain_port_b_out,
    output logic                       chain_port_b_oe_n,
    // Segment level selects, column k at index k-1
    output lscl_level_type [COLS-1:0]  segment_outputs
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] LVL_FULL = (PTR_W+1)'(DEPTH);

    lscl_pins_type          sync1_r;
    lscl_pins_type          sync2_r;
    logic                   strobe_prev_r;
    logic                   load_prev_r;
    logic                   accept_r;
    logic [CNT_W-1:0]       count_r;
    logic [COLS-1:0]        shreg_r;
    logic [COLS-1:0]        latch_r;
    logic [31:0]            ctrl_r;
    lscl_entry_type         mem_r [DEPTH];
    logic [PTR_W-1:0]       wr_ptr_r;
    logic [PTR_W-1:0]       rd_ptr_r;
    logic [PTR_W:0]         level_r;
    logic                   strobe_fall;
    logic                   load_rise;
    logic                   enable_in;
    logic                   push;
    logic                   pop;
    logic                   fifo_full;
    logic                   fifo_empty;
    lscl_entry_type         head;
    logic [31:0]            rd_mux;
    logic                   rd_hit;

    // Pointer step with wrap for any depth
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(DEPTH - 1))
            return '0;
        return p + PTR_W'(1);
    endfunction

    // Two-stage pin synchroniser; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= PINS_RESET;
            sync2_r <= PINS_RESET;
        end else begin
            sync1_r <= '{shift_strobe: data_shift_strobe, row_load: row_load_strobe,
                         polarity: polarity, blank_n: blanking_input_n,
                         dir: shift_direction_select, a_in: chain_port_a_in,
                         b_in: chain_port_b_in, nib: pixel_nibble};
            sync2_r <= sync1_r;
        end
    end

    // Edge history of the two strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_prev_r <= 1'b0;
            load_prev_r   <= 1'b0;
        end else begin
            strobe_prev_r <= sync2_r.shift_strobe;
            load_prev_r   <= sync2_r.row_load;
        end
    end

    assign strobe_fall = strobe_prev_r && !sync2_r.shift_strobe;
    assign load_rise   = !load_prev_r && sync2_r.row_load;

    // Role of the chain pins follows direction
    assign enable_in = sync2_r.dir ? sync2_r.a_in : sync2_r.b_in; // RULE9

    // Intake gate; load level has priority so no nibble counts during it
    assign push = strobe_fall && accept_r && !enable_in && !fifo_full && !sync2_r.row_load; // RULE2 RULE11 RULE17

    // Accept window and nibble count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_r <= 1'b0;
            count_r  <= CNT_RESET;
        end else if (sync2_r.row_load) begin
            accept_r <= 1'b1; // RULE4
            count_r  <= CNT_RESET;
        end else if (push) begin
            if (count_r == CNT_LAST) begin
                accept_r <= 1'b0; // RULE13 RULE14 RULE15
                count_r  <= CNT_RESET;
            end else begin
                count_r <= count_r + CNT_W'(1);
            end
        end
    end

    // Two-entry buffer; a drain stall lets it fill and drops intake_ready
    assign fifo_full    = (level_r == LVL_FULL);
    assign fifo_empty   = (level_r == '0);
    assign intake_ready = !fifo_full;
    assign pop          = !fifo_empty && !ctrl_r[CTRL_HOLD_BIT];
    assign head         = mem_r[rd_ptr_r];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= '{dir: sync2_r.dir, nib: sync2_r.nib};
                wr_ptr_r        <= ptr_next(wr_ptr_r);
            end
            if (pop)
                rd_ptr_r <= ptr_next(rd_ptr_r);
            if (push && !pop)
                level_r <= level_r + (PTR_W+1)'(1);
            else if (pop && !push)
                level_r <= level_r - (PTR_W+1)'(1);
        end
    end

    // Column shift in the direction stored with each nibble
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg_r <= '0;
        end else if (pop) begin
            if (!head.dir)
                shreg_r <= {shreg_r[COLS-NIB_W-1:0], head.nib}; // RULE1 RULE10
            else
                shreg_r <= {head.nib[0], head.nib[1], head.nib[2], head.nib[3], shreg_r[COLS-1:NIB_W]}; // RULE10
        end
    end

    // Line latch; nibbles still buffered at the load edge join the next line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            latch_r <= '0;
        else if (load_rise)
            latch_r <= shreg_r; // RULE3
    end

    // Bias selection per column; polarity is trusted to alternate by frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < COLS; k++)
                segment_outputs[k] <= LVL_UNSEL;
        end else begin
            for (int k = 0; k < COLS; k++)
                segment_outputs[k] <= lscl_level_sel(sync2_r.polarity, latch_r[k], sync2_r.blank_n); // RULE5 RULE6 RULE7 RULE8
        end
    end

    // Chain pins; the output-role pin mirrors the accept window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_port_a_out  <= 1'b0;
            chain_port_b_out  <= 1'b0;
            chain_port_a_oe_n <= 1'b0;
            chain_port_b_oe_n <= 1'b1;
        end else begin
            chain_port_a_oe_n <= sync2_r.dir; // RULE9
            chain_port_b_oe_n <= !sync2_r.dir;
            chain_port_a_out  <= !sync2_r.dir && accept_r; // RULE12 RULE13
            chain_port_b_out  <= sync2_r.dir && accept_r;
        end
    end

    // Control register write; only the hold bit is implemented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= CTRL_RESET;
        else if (psel && penable && pwrite && paddr == OFS_CTRL)
            ctrl_r <= {31'h0000_0000, pwdata[CTRL_HOLD_BIT]};
    end

    // Read decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL:   rd_mux = ctrl_r;
            OFS_STATUS: begin
                rd_mux[STAT_ACCEPT_BIT]                = accept_r;
                rd_mux[STAT_ENOUT_BIT]                 = accept_r;
                rd_mux[STAT_ENIN_BIT]                  = !enable_in;
                rd_mux[STAT_FIFO_LSB +: PTR_W+1]       = level_r;
                rd_mux[STAT_CNT_LSB +: CNT_W]          = count_r;
            end
            OFS_LATCH0: rd_mux = latch_r[31:0];
            OFS_LATCH1: rd_mux = latch_r[63:32];
            OFS_LATCH2: rd_mux = {16'h0000, latch_r[79:64]};
            default:    rd_hit = 1'b0;
        endcase
    end

    // Answer captured in the setup cycle so the access phase ends at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !rd_hit;
        end
    end

    assign pready = psel && penable;

    // Checks
    property p_shift_up;
        @(posedge pclk) disable iff (!presetn)
        (pop && !head.dir) |=> (shreg_r[3:0] == $past(head.nib)) && (shreg_r[7:4] == $past(shreg_r[3:0]));
    endproperty
    a_shift_up: assert property (p_shift_up) else $error("upward shift wrong"); // RULE1

    property p_shift_down;
        @(posedge pclk) disable iff (!presetn)
        (pop && head.dir) |=> (shreg_r[79] == $past(head.nib[0])) && (shreg_r[76] == $past(head.nib[3]));
    endproperty
    a_shift_down: assert property (p_shift_down) else $error("downward shift wrong"); // RULE10

    property p_ignore;
        @(posedge pclk) disable iff (!presetn)
        (!sync2_r.row_load && (!accept_r || enable_in)) |=> count_r == $past(count_r);
    endproperty
    a_ignore: assert property (p_ignore) else $error("strobe taken outside window"); // RULE2

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        load_rise |=> latch_r == $past(shreg_r);
    endproperty
    a_latch: assert property (p_latch) else $error("latch missed shift register"); // RULE3

    property p_init;
        @(posedge pclk) disable iff (!presetn)
        sync2_r.row_load |=> accept_r && count_r == CNT_RESET ##1 (sync2_r.dir ? chain_port_b_out : chain_port_a_out);
    endproperty
    a_init: assert property (p_init) else $error("load did not arm window"); // RULE12

    property p_blank;
        @(posedge pclk) disable iff (!presetn)
        !sync2_r.blank_n |=> segment_outputs == {COLS{LVL_UNSEL}};
    endproperty
    a_blank: assert property (p_blank) else $error("blanking not applied"); // RULE5

    property p_table;
        @(posedge pclk) disable iff (!presetn)
        sync2_r.blank_n |=> segment_outputs[0] ==
            ($past(sync2_r.polarity) ? ($past(latch_r[0]) ? LVL_NEG : LVL_FOURTH)
                                     : ($past(latch_r[0]) ? LVL_UNSEL : LVL_THIRD));
    endproperty
    a_table: assert property (p_table) else $error("bias selection wrong"); // RULE6

    property p_roles;
        @(posedge pclk) disable iff (!presetn)
        $stable(sync2_r.dir) |=> chain_port_a_oe_n == $past(sync2_r.dir) && chain_port_b_oe_n == !$past(sync2_r.dir);
    endproperty
    a_roles: assert property (p_roles) else $error("chain pin roles wrong"); // RULE9

    property p_complete;
        @(posedge pclk) disable iff (!presetn)
        (push && count_r == CNT_LAST) |=> !accept_r;
    endproperty
    a_complete: assert property (p_complete) else $error("window open after line"); // RULE14

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!accept_r && !sync2_r.row_load) |=> !accept_r;
    endproperty
    a_hold: assert property (p_hold) else $error("window reopened without load"); // RULE15

    // Output-role pin shows the window one edge late
    property p_enout;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ($past(sync2_r.dir) ? chain_port_b_out : chain_port_a_out) == $past(accept_r);
    endproperty
    a_enout: assert property (p_enout) else $error("enable output does not track window"); // RULE13

    // Input-role pin never shows a driven high
    property p_quiet;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ($past(sync2_r.dir) ? chain_port_a_out : chain_port_b_out) == 1'b0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("input-role pin driven"); // RULE9

    // Each accepted strobe below the last one advances the count by one
    property p_count;
        @(posedge pclk) disable iff (!presetn)
        (push && count_r != CNT_LAST) |=> count_r == $past(count_r) + CNT_W'(1);
    endproperty
    a_count: assert property (p_count) else $error("nibble count did not advance"); // RULE14

    c_line_done: cover property (@(posedge pclk) disable iff (!presetn) push && count_r == CNT_LAST);
    c_fifo_full: cover property (@(posedge pclk) disable iff (!presetn) fifo_full && strobe_fall);
    c_latch:     cover property (@(posedge pclk) disable iff (!presetn) load_rise && shreg_r != '0);
    c_down:      cover property (@(posedge pclk) disable iff (!presetn) pop && head.dir);
    c_blank:     cover property (@(posedge pclk) disable iff (!presetn) !sync2_r.blank_n && latch_r != '0);

endmodule

//--- test/lscl_ctrl_model.sv
// Behavioural LCD controller driving strobes, nibbles and polarity
module lscl_ctrl_model
    import lscl_pkg::*;
(
    // Clock
    input  wire logic             pclk,
    // Controller pins
    output logic                  data_shift_strobe,
    output logic                  row_load_strobe,
    output logic [NIB_W-1:0]      pixel_nibble,
    output logic                  polarity
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels, strobe parked high between frames
    initial begin
        data_shift_strobe = 1'b1;
        row_load_strobe   = 1'b0;
        pixel_nibble      = 4'h0;
        polarity          = 1'b0;
    end

    // One nibble per falling strobe; both phases span four clocks for the synchroniser
    task automatic send_nibble(input logic [NIB_W-1:0] n);
        @(posedge pclk);
        pixel_nibble      <= n;
        data_shift_strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        data_shift_strobe <= 1'b1;
        repeat (2) @(posedge pclk);
        pixel_nibble <= ~n; // Hold over, so the old value must not linger
        repeat (2) @(posedge pclk);
    endtask

    // Line load; polarity flips per line as the frame inversion source
    task automatic load_line();
        @(posedge pclk);
        row_load_strobe <= 1'b1;
        polarity        <= ~polarity;
        repeat (4) @(posedge pclk);
        row_load_strobe <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask
endmodule

//--- test/lscl_column_loader_tb_top.sv
// Self-checking bench for the LCD segment column loader
module lscl_column_loader_tb_top;
    import lscl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic                     strobe, load, pol, blank_n, dir, intake_ready, e;
    logic [NIB_W-1:0]         nib;
    logic                     a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, a_drv, b_drv;
    lscl_level_type [COLS-1:0] segs;
    logic [COLS-1:0]          exp_sh;
    int                       bad_count, n_tests;

    // Resolved chain wires, selected by the loader's active-low output enables
    assign a_in = a_oe_n ? a_drv : a_out;
    assign b_in = b_oe_n ? b_drv : b_out;

    lscl_column_loader lscl_column_loader_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_shift_strobe(strobe), .row_load_strobe(load), .pixel_nibble(nib), .polarity(pol),
        .blanking_input_n(blank_n), .shift_direction_select(dir), .intake_ready(intake_ready),
        .chain_port_a_in(a_in), .chain_port_a_out(a_out), .chain_port_a_oe_n(a_oe_n),
        .chain_port_b_in(b_in), .chain_port_b_out(b_out), .chain_port_b_oe_n(b_oe_n),
        .segment_outputs(segs));

    lscl_ctrl_model lscl_ctrl_model_inst (
        .pclk(pclk), .data_shift_strobe(strobe), .row_load_strobe(load),
        .pixel_nibble(nib), .polarity(pol));

    // Expected column register after one push
    function automatic logic [COLS-1:0] push(input logic [COLS-1:0] r, input logic [3:0] n, input logic d);
        if (d)
            return {n[0], n[1], n[2], n[3], r[COLS-1:4]};
        return {r[COLS-5:0], n};
    endfunction

    // Expected bias level of one segment
    function automatic lscl_level_type want_lvl(input logic p, input logic b, input logic bn);
        if (bn && p)
            return b ? LVL_NEG : LVL_FOURTH;
        if (bn && !b)
            return LVL_THIRD;
        return LVL_UNSEL;
    endfunction

    task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("unexpected %s expected %h seen %h", name, ex, got);
            bad_count++;
        end
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r       = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Random nibbles; only accepted ones enter the expected register
    task automatic feed(input int k, input logic keep);
        logic [3:0] n;
        repeat (k) begin
            n = 4'($urandom);
            lscl_ctrl_model_inst.send_nibble(n);
            if (keep)
                exp_sh = push(exp_sh, n, dir);
        end
    endtask

    task automatic check_latch();
        apb(OFS_LATCH0, 1'b0, 32'h0, rd, e);
        chk("latch0", exp_sh[31:0], rd);
        apb(OFS_LATCH1, 1'b0, 32'h0, rd, e);
        chk("latch1", exp_sh[63:32], rd);
        apb(OFS_LATCH2, 1'b0, 32'h0, rd, e);
        chk("latch2", {16'h0000, exp_sh[79:64]}, rd);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Watchdog, far beyond the roughly six hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, a_drv, b_drv, dir} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        blank_n = 1'b1;
        exp_sh = '0;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(32'h5BFF));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("a_oe_n", 32'h0, a_oe_n);
        chk("b_oe_n", 32'h1, b_oe_n);
        chk("a_out", 32'h0, a_out);
        chk("ready", 32'h1, intake_ready);
        apb(OFS_CTRL, 1'b0, 32'h0, rd, e);
        chk("ctrl", CTRL_RESET, rd);
        apb(8'h20, 1'b1, 32'hFFFF_FFFF, rd, e);
        chk("wr_err", 32'h1, e);
        apb(8'h20, 1'b0, 32'h0, rd, e);
        chk("rd_err", 32'h1, e);
        chk("rd_data", 32'h0, rd);
        apb(OFS_STATUS, 1'b1, 32'hFFFF_FFFF, rd, e);
        chk("ro_err", 32'h0, e);
        // Upward line with the buffer stalled until it refuses
        lscl_ctrl_model_inst.load_line();
        chk("a_out", 32'h1, a_out);
        chk("b_out", 32'h0, b_out);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("window", 32'h1, rd[STAT_ACCEPT_BIT]);
        chk("en_out", 32'h1, rd[STAT_ENOUT_BIT]);
        // Port B as enable input, a high level keeps intake off
        @(posedge pclk);
        b_drv <= 1'b1;
        feed(1, 1'b0);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("count", 32'h0, rd[12:8]);
        b_drv <= 1'b0;
        apb(OFS_CTRL, 1'b1, 32'h1, rd, e);
        feed(2, 1'b1);
        chk("ready", 32'h0, intake_ready);
        feed(1, 1'b0);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("level", 32'h2, rd[5:4]);
        chk("count", 32'h2, rd[12:8]);
        apb(OFS_CTRL, 1'b1, 32'h0, rd, e);
        feed(18, 1'b1);
        repeat (4) @(posedge pclk);
        chk("a_out", 32'h0, a_out);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("window", 32'h0, rd[STAT_ACCEPT_BIT]);
        feed(1, 1'b0);
        lscl_ctrl_model_inst.load_line();
        check_latch();
        // Downward line, first held off by the enable input
        @(posedge pclk);
        dir   <= 1'b1;
        a_drv <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("a_oe_n", 32'h1, a_oe_n);
        chk("b_oe_n", 32'h0, b_oe_n);
        lscl_ctrl_model_inst.load_line();
        chk("b_out", 32'h1, b_out);
        feed(2, 1'b0);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("count", 32'h0, rd[12:8]);
        chk("en_in", 32'h0, rd[STAT_ENIN_BIT]);
        @(posedge pclk);
        a_drv <= 1'b0;
        feed(20, 1'b1);
        repeat (4) @(posedge pclk);
        chk("b_out", 32'h0, b_out);
        lscl_ctrl_model_inst.load_line();
        check_latch();
        // Level selection under both polarities and blanking
        repeat (2) begin
            lscl_ctrl_model_inst.load_line();
            for (int bn = 0; bn < 2; bn++) begin
                @(posedge pclk);
                blank_n <= bn[0];
                repeat (6) @(posedge pclk);
                for (int k = 0; k < COLS; k++)
                    chk("segment", want_lvl(pol, exp_sh[k], blank_n), segs[k]);
            end
        end
        // Mid-run reset closes the window and clears the latch
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("b_out", 32'h0, b_out);
        apb(OFS_STATUS, 1'b0, 32'h0, rd, e);
        chk("window", 32'h0, rd[STAT_ACCEPT_BIT]);
        apb(OFS_LATCH0, 1'b0, 32'h0, rd, e);
        chk("latch0", 32'h0, rd);
        wrap_up();
    end
endmodule
